// ===== inc/bcs_pkg.sv
// Purpose: shared constants and types for the battery charge state machine
// Assumes: 100 MHz system clock, all timers counted in one-second ticks
// Notes:   state codes follow a Gray path off, prequal, cc, cv, top-off, done
package bcs_pkg;

  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned TICK_TIME_MS   = 1000;
  localparam int unsigned TICK_CYCLES    = TICK_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W          = 15;
  localparam int unsigned SEC_PER_MIN    = 60;
  localparam int unsigned SEC_PER_HOUR   = 3600;

  // ----------------------------------------------------------------
  // timer lengths (ticks are seconds)
  // ----------------------------------------------------------------
  localparam int unsigned PQ_TIME_MIN       = 30;
  localparam int unsigned SAFETY_BASE_HOUR  = 3;
  localparam int unsigned SAFETY_STEP_HOUR  = 2;
  localparam logic [1:0]  SAFETY_OFF_CODE   = 2'h0;
  localparam int unsigned FINISH_STEP_MIN   = 5;
  localparam logic [TMR_W-1:0] PQ_LIMIT     = TMR_W'(PQ_TIME_MIN * SEC_PER_MIN);

  // ----------------------------------------------------------------
  // voltage coding: regulation field is base plus code times step
  // ----------------------------------------------------------------
  localparam logic [12:0] V_BASE_MV     = 13'h0E10;   // 3600 mV
  localparam logic [12:0] V_STEP_MV     = 13'h0019;   // 25 mV
  localparam logic [12:0] SYS_MARGIN_MV = 13'h00C8;   // 200 mV
  localparam logic [5:0]  V_CODE_MAX    = 6'h28;      // 4600 mV

  // termination current percentages, selected by a two-bit field
  localparam logic [6:0] TERM_PCT0 = 7'h05;
  localparam logic [6:0] TERM_PCT1 = 7'h0A;
  localparam logic [6:0] TERM_PCT2 = 7'h14;
  localparam logic [6:0] TERM_PCT3 = 7'h1E;

  // ----------------------------------------------------------------
  // temperature zones reported by the comparators
  // ----------------------------------------------------------------
  localparam logic [2:0] ZN_NORMAL = 3'h0;
  localparam logic [2:0] ZN_WARM   = 3'h1;
  localparam logic [2:0] ZN_COOL   = 3'h2;
  localparam logic [2:0] ZN_HOT    = 3'h3;
  localparam logic [2:0] ZN_COLD   = 3'h4;

  typedef enum logic [3:0] {
    ST_OFF    = 4'h0,
    ST_PREQ   = 4'h1,
    ST_CC     = 4'h3,
    ST_CV     = 4'h2,
    ST_TOPOFF = 4'h6,
    ST_DONE   = 4'h7,
    ST_JCC    = 4'h5,
    ST_JCV    = 4'h4,
    ST_PQ_F   = 4'hC,
    ST_FC_F   = 4'hD,
    ST_TEMP_F = 4'hE
  } bcs_state_t;

endpackage : bcs_pkg

// ===== hw/bcs_timer.sv
// Purpose: tick counter with synchronous clear, pause and expiry compare
// Assumes: i_tick is a one-cycle pulse from the shared timebase
// Notes:   counter saturates at the limit so expiry stays asserted
`timescale 1ns/10ps
`default_nettype none
module bcs_timer #(
  parameter int unsigned W = 15
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clear,
  input  wire logic         i_run,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_limit,
  output logic              o_expired
);
  logic [W-1:0] count;

  // clear wins over counting; saturation avoids wrap-around re-arming
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_clear) begin
      count <= '0;
    end else if (i_run && i_tick && count < i_limit) begin
      count <= count + W'(1);
    end
  end

  assign o_expired = (count >= i_limit);
endmodule // bcs_timer
`default_nettype wire

// ===== hw/bcs_charger.sv
// Purpose: control state machine of a linear battery charger
// Assumes: comparator inputs are asynchronous, settings come from logic on i_sys_clk
// Notes:   timers count one-second ticks; shorten P_TICK_CYCLES in simulation
//
// Notes on behaviour
// RULE1: low battery stays in prequalification
// RULE2: enable cleared keeps charger off
// RULE3: four-bit state field, maskable change event
// RULE4: prequal to constant current above threshold
// RULE5: cc requests six-bit current setting
// RULE6: reach regulation voltage, enter cv, hold
// RULE7: cv enters top-off below termination current
// RULE8: safety timer starts entering cc, runs
// RULE9: safety length 3/5/7 hours, 00 off
// RULE10: safety expiry faults, stops, disconnects
// RULE11: safety timer pauses below 20%, supplement
// RULE12: status bit shows safety timer suspended
// RULE13: termination current is selectable percentage
// RULE14: top-off timer 0-35 minutes then done
// RULE15: done disconnects, restarts on 150mV drop
// RULE16: prequal 30 minutes timeout faults
// RULE17: faults cleared by enable or input toggle
// RULE18: hot or cold enters temperature fault
// RULE19: temperature fault wins, returns to previous
// RULE20: fault pauses timers, resets safety, top-off
// RULE21: three-bit temperature status field
// RULE22: warm or cool enters modified states
// RULE23: modified states use alternate settings
// RULE24: lower regulation voltage for 200mV margin
// RULE25: synchronized inputs, common slow timebase
`timescale 1ns/10ps
`default_nettype none
module bcs_charger
  import bcs_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = bcs_pkg::TICK_CYCLES
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_input_valid,
  input  wire logic                    i_batt_above_pq,
  input  wire logic                    i_volt_reached,
  input  wire logic                    i_below_term,
  input  wire logic                    i_below_20pct,
  input  wire logic                    i_supplement,
  input  wire logic                    i_batt_restart_low,
  input  wire logic [2:0]              i_temp_zone,
  input  wire logic                    i_charger_enable_bit,
  input  wire logic                    i_thermistor_enable_bit,
  input  wire logic [5:0]              i_fast_current_setting,
  input  wire logic [5:0]              i_alternate_current_setting,
  input  wire logic [5:0]              i_regulation_voltage_setting,
  input  wire logic [5:0]              i_alternate_voltage_setting,
  input  wire logic [1:0]              i_safety_timer_length,
  input  wire logic [2:0]              i_finish_timer_length,
  input  wire logic [1:0]              i_term_select,
  input  wire logic [12:0]             i_sys_voltage_mv,
  input  wire logic                    i_state_event_mask,
  output logic [3:0]                   o_charger_state_field,
  output logic                         o_state_change_event,
  output logic                         o_charge_on,
  output logic                         o_prequal_mode,
  output logic                         o_cv_mode,
  output logic                         o_batt_connect,
  output logic [5:0]                   o_current_request,
  output logic [5:0]                   o_voltage_request,
  output logic [12:0]                  o_term_current,
  output logic [5:0]                   o_regulation_voltage_setting,
  output logic                         o_config_error_event,
  output logic                         o_safety_timer_suspended,
  output logic [2:0]                   o_temperature_status_field
);
  import bcs_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] meta;
  logic [NSYNC-1:0] sync;
  logic             valid_s, above_pq, v_reached, below_term, below_20, supp, restart_low;
  logic [2:0]       zone;

  // two flops per comparator input before any decision logic [RULE25]
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= {i_temp_zone, i_batt_restart_low, i_supplement, i_below_20pct,
               i_below_term, i_volt_reached, i_batt_above_pq, i_input_valid};
      sync <= meta;
    end
  end
  assign {zone, restart_low, supp, below_20, below_term, v_reached, above_pq, valid_s} = sync;

  // ----------------------------------------------------------------
  // one-second timebase
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;

  // one shared divider keeps all three timers in step [RULE25]
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == 32'(P_TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // temperature classification and settings
  // ----------------------------------------------------------------
  logic       thm_fault, thm_mod;
  logic [5:0] v_code_eff;
  logic [12:0] v_mv;

  assign thm_fault = i_thermistor_enable_bit && (zone == ZN_HOT || zone == ZN_COLD);  // [RULE18]
  assign thm_mod   = i_thermistor_enable_bit && (zone == ZN_WARM || zone == ZN_COOL);  // [RULE22]

  // lower the code until the system rail is 200 mV above it [RULE24]
  assign v_mv = V_BASE_MV + 13'(i_regulation_voltage_setting * V_STEP_MV);
  always_comb begin
    v_code_eff = i_regulation_voltage_setting;
    if (v_mv + SYS_MARGIN_MV > i_sys_voltage_mv) begin
      if (i_sys_voltage_mv < V_BASE_MV + SYS_MARGIN_MV) begin
        v_code_eff = 6'h00;
      end else begin
        v_code_eff = 6'((i_sys_voltage_mv - V_BASE_MV - SYS_MARGIN_MV) / V_STEP_MV);
      end
    end
    if (v_code_eff > V_CODE_MAX) begin
      v_code_eff = V_CODE_MAX;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  bcs_state_t        state, next_state, saved;
  logic              pq_exp, fc_exp_raw, to_exp, fc_exp;
  logic              is_fast, next_fast, fc_pause;
  logic [TMR_W-1:0]  fc_limit, to_limit;

  assign is_fast   = (state == ST_CC || state == ST_CV || state == ST_JCC || state == ST_JCV);
  assign next_fast = (next_state == ST_CC || next_state == ST_CV ||
                      next_state == ST_JCC || next_state == ST_JCV);
  // pause below 20% in constant current and during supplement [RULE11]
  assign fc_pause  = supp || (below_20 && (state == ST_CC || state == ST_JCC));
  // 3, 5 or 7 hours; code 00 never expires [RULE9]
  assign fc_limit  = TMR_W'((SAFETY_BASE_HOUR + SAFETY_STEP_HOUR * (32'(i_safety_timer_length) - 32'h1))
                            * SEC_PER_HOUR);
  assign fc_exp    = fc_exp_raw && (i_safety_timer_length != SAFETY_OFF_CODE);
  assign to_limit  = TMR_W'(32'(i_finish_timer_length) * FINISH_STEP_MIN * SEC_PER_MIN);  // [RULE14]

  // prequal timer cleared only while off, so it resumes after a temperature fault [RULE20]
  bcs_timer #(.W(TMR_W)) u_pq_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (state == ST_OFF),
    .i_run     (state == ST_PREQ),
    .i_tick    (tick),
    .i_limit   (PQ_LIMIT),
    .o_expired (pq_exp)
  );

  // restarts on entry to the fast states from elsewhere, including fault exit [RULE8] [RULE20]
  bcs_timer #(.W(TMR_W)) u_fc_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (next_fast && !is_fast),
    .i_run     (is_fast && !fc_pause),
    .i_tick    (tick),
    .i_limit   (fc_limit),
    .o_expired (fc_exp_raw)
  );

  // restarts on each entry to top-off; zero length completes at once [RULE14] [RULE20]
  bcs_timer #(.W(TMR_W)) u_to_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (next_state == ST_TOPOFF && state != ST_TOPOFF),
    .i_run     (state == ST_TOPOFF),
    .i_tick    (tick),
    .i_limit   (to_limit),
    .o_expired (to_exp)
  );

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  bcs_state_t cc_pick, cv_pick;
  assign cc_pick = thm_mod ? ST_JCC : ST_CC;  // [RULE22]
  assign cv_pick = thm_mod ? ST_JCV : ST_CV;

  // disable and input loss outrank all, then temperature fault [RULE2] [RULE19]
  always_comb begin
    next_state = state;
    if (!i_charger_enable_bit || !valid_s) begin
      next_state = ST_OFF;  // [RULE2] [RULE17]
    end else if (thm_fault && state != ST_OFF && state != ST_TEMP_F) begin
      next_state = ST_TEMP_F;  // [RULE18]
    end else begin
      case (state)
        ST_OFF: begin
          if (!above_pq) begin
            next_state = ST_PREQ;
          end else if (restart_low) begin
            next_state = cc_pick;
          end
        end
        ST_PREQ: begin
          if (above_pq) begin
            next_state = cc_pick;  // [RULE4]
          end else if (pq_exp) begin
            next_state = ST_PQ_F;  // [RULE16]
          end else begin
            next_state = ST_PREQ;  // [RULE1]
          end
        end
        ST_CC, ST_JCC: begin
          if (fc_exp) begin
            next_state = ST_FC_F;  // [RULE10]
          end else if (v_reached) begin
            next_state = cv_pick;  // [RULE6]
          end else begin
            next_state = cc_pick;  // [RULE23]
          end
        end
        ST_CV, ST_JCV: begin
          if (fc_exp) begin
            next_state = ST_FC_F;  // [RULE10]
          end else if (below_term) begin
            next_state = ST_TOPOFF;  // [RULE7]
          end else begin
            next_state = cv_pick;  // [RULE23]
          end
        end
        ST_TOPOFF: begin
          if (to_exp) begin
            next_state = ST_DONE;  // [RULE14]
          end
        end
        ST_DONE: begin
          if (restart_low) begin
            next_state = above_pq ? cc_pick : ST_PREQ;  // [RULE15]
          end
        end
        ST_TEMP_F: begin
          if (!thm_fault) begin
            next_state = saved;  // [RULE19]
          end
        end
        ST_PQ_F, ST_FC_F: next_state = state;  // [RULE17]
        default: next_state = ST_OFF;
      endcase
    end
  end

  // state register and the state to resume after a temperature fault
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= ST_OFF;
      saved <= ST_OFF;
    end else begin
      state <= next_state;
      if (next_state == ST_TEMP_F && state != ST_TEMP_F) begin
        saved <= state;  // [RULE19]
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic       chg_on_n, jeita_n, cv_n, conn_n;
  logic [5:0] cur_n;
  logic [6:0] pct;
  logic       cfg_bad, cfg_bad_q;

  assign chg_on_n = (next_state == ST_PREQ || next_state == ST_TOPOFF || next_fast);
  assign jeita_n  = (next_state == ST_JCC || next_state == ST_JCV);
  assign cv_n     = (next_state == ST_CV || next_state == ST_JCV || next_state == ST_TOPOFF);  // [RULE13]
  // faults, done and off with valid input keep the cell off the system rail [RULE10] [RULE15] [RULE18]
  assign conn_n   = !(next_state == ST_DONE || next_state == ST_PQ_F || next_state == ST_FC_F ||
                      next_state == ST_TEMP_F || (next_state == ST_OFF && valid_s));
  assign cur_n    = jeita_n ? i_alternate_current_setting : i_fast_current_setting;  // [RULE5] [RULE23]
  assign cfg_bad  = (v_code_eff != i_regulation_voltage_setting);

  always_comb begin
    case (i_term_select)
      2'h0:    pct = TERM_PCT0;
      2'h1:    pct = TERM_PCT1;
      2'h2:    pct = TERM_PCT2;
      default: pct = TERM_PCT3;
    endcase
  end

  // drive requests and state reporting one edge after the decision
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_charger_state_field <= ST_OFF;
      o_state_change_event  <= 1'b0;
      o_charge_on           <= 1'b0;
      o_prequal_mode        <= 1'b0;
      o_cv_mode             <= 1'b0;
      o_batt_connect        <= 1'b1;
      o_current_request     <= 6'h00;
      o_voltage_request     <= 6'h00;
      o_term_current        <= 13'h0000;
    end else begin
      o_charger_state_field <= next_state;  // [RULE3]
      o_state_change_event  <= (next_state != state) && !i_state_event_mask;  // [RULE3]
      o_charge_on           <= chg_on_n;  // [RULE10] [RULE16] [RULE18]
      o_prequal_mode        <= (next_state == ST_PREQ);  // [RULE1]
      o_cv_mode             <= cv_n;  // [RULE6]
      o_batt_connect        <= conn_n;
      o_current_request     <= chg_on_n ? cur_n : 6'h00;  // [RULE5]
      o_voltage_request     <= jeita_n ? i_alternate_voltage_setting : v_code_eff;  // [RULE6] [RULE23]
      o_term_current        <= 13'(cur_n) * 13'(pct);  // widen first, product needs 11 bits [RULE13]
    end
  end

  // status fields and configuration check
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_regulation_voltage_setting <= 6'h00;
      o_config_error_event         <= 1'b0;
      o_safety_timer_suspended     <= 1'b0;
      o_temperature_status_field   <= ZN_NORMAL;
      cfg_bad_q                    <= 1'b0;
    end else begin
      cfg_bad_q                    <= cfg_bad;
      o_regulation_voltage_setting <= v_code_eff;  // [RULE24]
      o_config_error_event         <= cfg_bad && !cfg_bad_q;  // [RULE24]
      o_safety_timer_suspended     <= is_fast && fc_pause;  // [RULE12]
      o_temperature_status_field   <= zone;  // [RULE21]
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_off_when_disabled: assert property (!i_charger_enable_bit |=> o_charger_state_field == ST_OFF)  // [RULE2]
    else $error("charger not off while disabled");
  a_field_tracks_state: assert property (o_charger_state_field == state)  // [RULE3]
    else $error("state field differs from state");
  a_event_on_change: assert property ($changed(state) && !$past(i_state_event_mask) |-> o_state_change_event)  // [RULE3]
    else $error("state change without event");
  a_preq_exit_cc: assert property (state == ST_PREQ && next_state != ST_OFF && next_state != ST_TEMP_F
    && above_pq |=> state == ST_CC || state == ST_JCC)  // [RULE4]
    else $error("prequal did not move to cc");
  a_fault_no_current: assert property (state inside {ST_PQ_F, ST_FC_F, ST_TEMP_F} |-> !o_charge_on && !o_batt_connect)  // [RULE10]
    else $error("current or connection during fault");
  a_cv_to_topoff: assert property (state == ST_CV && below_term && !fc_exp && !thm_fault && i_charger_enable_bit
    && valid_s |=> state == ST_TOPOFF)  // [RULE7]
    else $error("cv did not enter top-off");
  a_zero_finish: assert property (state == ST_TOPOFF && i_finish_timer_length == 3'h0 && !thm_fault
    && i_charger_enable_bit && valid_s |=> state == ST_DONE)  // [RULE14]
    else $error("zero top-off did not complete");
  a_temp_return: assert property (state == ST_TEMP_F && !thm_fault && i_charger_enable_bit && valid_s
    |=> state == $past(saved))  // [RULE19]
    else $error("temperature fault did not resume");
  a_susp_status: assert property (is_fast && supp |=> o_safety_timer_suspended)  // [RULE12]
    else $error("suspended bit missing in supplement");
  a_margin_kept: assert property (##1 i_sys_voltage_mv >= V_BASE_MV + SYS_MARGIN_MV
    && $stable(i_regulation_voltage_setting) && $stable(i_sys_voltage_mv) |->
    V_BASE_MV + 13'(o_regulation_voltage_setting * V_STEP_MV) + SYS_MARGIN_MV <= i_sys_voltage_mv)  // [RULE24]
    else $error("regulation voltage margin violated");

  c_full_cycle:  cover property (state == ST_TOPOFF ##1 state == ST_DONE);
  c_temp_fault:  cover property (state == ST_TEMP_F ##[1:20] state == ST_CC);
  c_jeita:       cover property (state == ST_CC ##1 state == ST_JCC);
  c_cfg_error:   cover property (o_config_error_event);
endmodule // bcs_charger
`default_nettype wire

// ===== dv/bcs_batt_model.sv
// Purpose: stand-in for the cell and the analog charge loops
// Assumes: the level moves one step a clock toward a goal set by the bench
// Notes:   the level only rises while charge current is enabled
`timescale 1ns/10ps
`default_nettype none
module bcs_batt_model #(
  parameter int PQ_LVL  = 64,
  parameter int FULL    = 200,
  parameter int RESTART = 6
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_charge_on,
  input  wire logic       i_cv_mode,
  input  wire logic [7:0] i_goal,
  output logic            o_above_pq,
  output logic            o_full,
  output logic            o_below_term,
  output logic            o_restart_low
);
  logic [7:0] lvl;
  // self discharge needs no current; voltage hold stops the rise, so no overshoot
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) lvl <= 8'h00;
    else if (i_goal < lvl) lvl <= lvl - 8'h01;
    else if (i_goal > lvl && i_charge_on && !i_cv_mode) lvl <= lvl + 8'h01;
  end
  // comparator levels; current tapers only once held at full voltage
  assign o_above_pq    = (int'(lvl) > PQ_LVL);
  assign o_full        = (int'(lvl) >= FULL);
  assign o_below_term  = i_cv_mode && o_full;
  assign o_restart_low = (int'(lvl) < FULL - RESTART);
endmodule // bcs_batt_model
`default_nettype wire

// ===== dv/bcs_charger_tb.sv
// Purpose: self-checking bench for the charger state machine
// Assumes: tick shortened to 2 cycles, so one hour is 7200 cycles
// Notes:   settings rows first, then charge, fault and temperature cases
`timescale 1ns/10ps
`default_nettype none
module bcs_charger_tb;
  import bcs_pkg::*;
  // ----------------------------------------------------------------
  // signals, partner and design
  // ----------------------------------------------------------------
  typedef struct packed {logic [2:0] zn; logic [5:0] vc; logic [12:0] mv; logic [5:0] ev; logic er;} bcs_row_t;
  bcs_row_t rows [5] = '{'{3'h0, 6'h28, 13'h12C0, 6'h28, 1'b0}, '{3'h1, 6'h28, 13'h12BF, 6'h27, 1'b1},
    '{3'h2, 6'h10, 13'h1068, 6'h10, 1'b0}, '{3'h3, 6'h10, 13'h1067, 6'h0F, 1'b1}, '{3'h4, 6'h00, 13'h0ED8, 6'h00, 1'b0}};
  logic i_sys_clk, i_rst_n, i_input_valid, i_batt_above_pq, i_volt_reached, i_below_term, i_below_20pct;
  logic i_supplement, i_batt_restart_low, i_charger_enable_bit, i_thermistor_enable_bit, i_state_event_mask;
  logic [2:0] i_temp_zone, o_temperature_status_field;
  logic [5:0] i_fast_current_setting = 6'h2A, i_alternate_current_setting = 6'h11;
  logic [5:0] i_regulation_voltage_setting, i_alternate_voltage_setting = 6'h08;
  logic [5:0] o_current_request, o_voltage_request, o_regulation_voltage_setting;
  logic [1:0] i_safety_timer_length, i_term_select = 2'h1;
  logic [2:0] i_finish_timer_length = 3'h0;
  logic [12:0] i_sys_voltage_mv, o_term_current, p;
  logic [3:0] o_charger_state_field;
  logic o_state_change_event, o_charge_on, o_prequal_mode, o_cv_mode, o_batt_connect;
  logic o_config_error_event, o_safety_timer_suspended;
  logic [7:0] goal;
  int error_cnt = 0;
  int tests_run = 0;

  bcs_charger #(.P_TICK_CYCLES(2)) dut_u (.*);
  bcs_batt_model batt_u (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (i_rst_n),
    .i_charge_on   (o_charge_on),
    .i_cv_mode     (o_cv_mode),
    .i_goal        (goal),
    .o_above_pq    (i_batt_above_pq),
    .o_full        (i_volt_reached),
    .o_below_term  (i_below_term),
    .o_restart_low (i_batt_restart_low)
  );
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------------------------------
  // compare, bounded wait and closing report
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the event is judged in the first cycle the new state shows
  task automatic wait_st(input logic [3:0] exp, input int lim);
    int n;
    n = 0;
    while (o_charger_state_field !== exp && n < lim) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(13'(o_charger_state_field), 13'(exp));
    if (o_charger_state_field !== exp) final_report();
    chk(13'(o_state_change_event), 13'(!i_state_event_mask));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rst_n, i_charger_enable_bit, i_thermistor_enable_bit, i_below_20pct, i_supplement} = 5'h00;
    {i_state_event_mask, i_input_valid, i_temp_zone, goal} = {1'b0, 1'b1, ZN_NORMAL, 8'h20};
    {i_regulation_voltage_setting, i_sys_voltage_mv, i_safety_timer_length} = {6'h20, 13'h12C0, 2'h1};
    repeat (16) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    chk(13'(o_charge_on), 13'h0);
    // settings rows: margin correction, one pulse per new need, zone status
    foreach (rows[i]) begin
      {i_temp_zone, i_regulation_voltage_setting, i_sys_voltage_mv} = {rows[i].zn, rows[i].vc, rows[i].mv};
      p = 13'h0;
      repeat (6) begin
        @(negedge i_sys_clk);
        p = p + 13'(o_config_error_event);
      end
      chk(13'(o_regulation_voltage_setting), 13'(rows[i].ev));
      chk(p, 13'(rows[i].er));
      chk(13'(o_temperature_status_field), 13'(rows[i].zn));
    end
    {i_temp_zone, i_regulation_voltage_setting, i_sys_voltage_mv} = {ZN_NORMAL, 6'h20, 13'h12C0};
    // deep cell: prequal must last the full 30 minutes, then fault
    i_charger_enable_bit = 1'b1;
    wait_st(ST_PREQ, 50);
    chk(13'(o_prequal_mode), 13'h1);
    repeat (3000) @(negedge i_sys_clk);
    chk(13'(o_charger_state_field), 13'(ST_PREQ));
    wait_st(ST_PQ_F, 700);
    chk(13'(o_charge_on), 13'h0);
    i_input_valid = 1'b0;
    wait_st(ST_OFF, 20);
    {i_input_valid, goal} = {1'b1, 8'h96};
    wait_st(ST_PREQ, 20);
    wait_st(ST_CC, 100);
    chk(13'(o_current_request), 13'h2A);
    chk(o_term_current, 13'h1A4);
    // warm zone swaps settings, hot zone faults and returns to cc
    {i_thermistor_enable_bit, i_temp_zone} = {1'b1, ZN_WARM};
    wait_st(ST_JCC, 20);
    chk(13'(o_current_request), 13'h11);
    chk(13'(o_voltage_request), 13'h08);
    i_temp_zone = ZN_NORMAL;
    wait_st(ST_CC, 20);
    i_temp_zone = ZN_HOT;
    wait_st(ST_TEMP_F, 20);
    chk(13'({o_charge_on, o_batt_connect}), 13'h0);
    i_temp_zone = ZN_NORMAL;
    wait_st(ST_CC, 20);
    i_below_20pct = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    chk(13'(o_safety_timer_suspended), 13'h1);
    {i_below_20pct, i_supplement} = 2'b01;
    repeat (6) @(negedge i_sys_clk);
    chk(13'(o_safety_timer_suspended), 13'h1);
    i_supplement = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    chk(13'(o_safety_timer_suspended), 13'h0);
    // three hours is 21600 cycles, restarted when the temperature fault ended
    i_state_event_mask = 1'b1;
    repeat (20000) @(negedge i_sys_clk);
    chk(13'(o_charger_state_field), 13'(ST_CC));
    wait_st(ST_FC_F, 3000);
    chk(13'({o_charge_on, o_batt_connect}), 13'h0);
    {i_charger_enable_bit, i_state_event_mask} = 2'b00;
    wait_st(ST_OFF, 20);
    chk(13'(o_charge_on), 13'h0);
    {i_safety_timer_length, goal, i_charger_enable_bit} = {2'h0, 8'hFF, 1'b1};
    wait_st(ST_CC, 20);
    wait_st(ST_CV, 100);
    chk(13'(o_voltage_request), 13'h20);
    wait_st(ST_TOPOFF, 20);
    chk(13'(o_cv_mode), 13'h1);
    wait_st(ST_DONE, 2);
    chk(13'({o_charge_on, o_batt_connect}), 13'h0);
    goal = 8'h64;
    wait_st(ST_CC, 40);
    final_report();
  end
endmodule // bcs_charger_tb
`default_nettype wire
